// >>> inc/paf_pkg.sv
`default_nettype none
package paf_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS     = 10;
  localparam int SPIKE_FILTER_NS   = 50;
  // least stable time, rounded up to whole cycles
  localparam int SPIKE_FILTER_CYC  =
    (SPIKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIVIDED_CLOCK_OUT_HALF_DEFAULT = 1;
  localparam int CNT_W             = 16;

  // ************************************************************
  // pin positions
  // ************************************************************
  localparam int PB_DIVIDED_CLOCK_OUT = 0;
  localparam int PB_TIMER16_COMPARE_A_OUT = 1;
  localparam int PB_SS   = 2;
  localparam int PB_MOSI = 3;
  localparam int PB_MISO = 4;
  localparam int PB_SCK  = 5;
  localparam int PB_OSC1 = 6;
  localparam int PB_OSC2 = 7;
  localparam int PC_SCL  = 5;
  localparam int PC_RST  = 6;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] PB_OE_N_RST = 8'hFF;
  localparam logic [6:5] PC_OE_N_RST = 2'h3;
  localparam logic       SCL_IDLE    = 1'h1;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic value_override_enable;
    logic value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } paf_ovr_t;

  typedef struct packed {
    logic out;
    logic drive;
    logic pull;
    logic die;
  } paf_pad_t;

  localparam paf_ovr_t OVR_NONE = '0;

  // priority mux of overrides over the port register paths
  function automatic paf_pad_t paf_resolve(input paf_ovr_t o,
                                           input logic port,
                                           input logic dir,
                                           input logic global_pullup_disable,
                                           input logic die_normal);
    paf_pad_t p;
    p.drive = o.direction_override_enable ? o.direction_override_value : dir;
    p.out   = o.value_override_enable ? o.value_override_value : port;
    p.pull  = o.pullup_override_enable ? o.pullup_override_value
                                       : (port & ~dir & ~global_pullup_disable);
    p.die   = o.input_enable_override_enable ? o.input_enable_override_value
                                             : die_normal;
    return p;
  endfunction

endpackage
`default_nettype wire

// >>> hdl/paf_spike_filter.sv
`timescale 1ns/1ps
`default_nettype none
module paf_spike_filter
  import paf_pkg::*;
#(
  parameter int STABLE_CYCLES = SPIKE_FILTER_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic sample,
  output logic      level
);

  logic [7:0] cnt_reg;

  // ************************************************************
  // level follows input only after it held steady
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      level   <= SCL_IDLE;
    end else if (sample == level) begin
      cnt_reg <= '0;                       // spike ended, start over
    end else if (cnt_reg == 8'(STABLE_CYCLES - 1)) begin
      cnt_reg <= '0;
      level   <= sample;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_low_held;
    !sample [*5];
  endsequence

  property p_filter_pass;
    @(posedge clk_sys) disable iff (!rst_n)
    s_low_held |=> !level;
  endproperty
  a_filter_pass: assert property (p_filter_pass)
    else $error("steady low not passed by filter");

  // four low samples from a settled high level are a spike
  sequence s_short_low;
    !sample [*4];
  endsequence

  property p_filter_reject;
    @(posedge clk_sys) disable iff (!rst_n)
    (level && sample) ##1 s_short_low ##1 sample |=> level;
  endproperty
  a_filter_reject: assert property (p_filter_reject)
    else $error("short spike passed filter");

endmodule
`default_nettype wire

// >>> hdl/paf_port_override.sv
// Contract
// - spi slave forces select pin to input
// - slave active only while select held low
// - forced spi inputs keep port-bit pull-up
// - timer16 compare b drives b2 when output
// - timer16 compare a drives b1 when output
// - clock fuse drives divided clock on b0
// - divided clock stays out during chip reset
// - pin change mask enables b5..b0 input
// - oscillator use sets b7/b6 input enable, else mask enables it
// - oscillator use kills b7/b6 pull-up, driver
// - b4 master input, slave output data
// - b3 value is master out or compare
// - fuse programmed makes c6 general i/o, direction from register
// - fuse unprogrammed connects c6 to reset
// - c6 as reset reads zero everywhere
// - two-wire enable takes over c5 as clock
// - filter spikes under 50ns, open drain
// - b0 input feeds capture and change logic
// - value override replaces port bit when driving
`timescale 1ns/1ps
`default_nettype none
module paf_port_override
  import paf_pkg::*;
#(
  parameter int DIVIDED_CLOCK_OUT_HALF = DIVIDED_CLOCK_OUT_HALF_DEFAULT
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_N,
  input  wire logic       CHIP_RESET,
  input  wire logic       SLEEP_INPUT_DISABLE,
  input  wire logic       GLOBAL_PULLUP_DISABLE,
  input  wire logic [7:0] PORTB_OUTPUT,
  input  wire logic [7:0] PORTB_DIRECTION,
  input  wire logic [6:5] PORTC_OUTPUT,
  input  wire logic [6:5] PORTC_DIRECTION,
  input  wire logic       SPI_ENABLE_BIT,
  input  wire logic       SPI_MASTER_SELECT,
  input  wire logic       SPI_SCK_OUT,
  input  wire logic       SPI_MASTER_OUT,
  input  wire logic       SPI_SLAVE_OUT,
  input  wire logic       TIMER16_COMPARE_A_EN,
  input  wire logic       TIMER16_COMPARE_A_OUT,
  input  wire logic       TIMER16_COMPARE_B_EN,
  input  wire logic       TIMER16_COMPARE_B_OUT,
  input  wire logic       TIMER8B_COMPARE_A_EN,
  input  wire logic       TIMER8B_COMPARE_A_OUT,
  input  wire logic       CLOCK_OUT_FUSE,
  input  wire logic       RESET_PIN_DISABLE_FUSE,
  input  wire logic       INTERNAL_RC_SELECTED,
  input  wire logic       EXTERNAL_CLOCK_SELECTED,
  input  wire logic       ASYNC_TIMER_ENABLE,
  input  wire logic       PORTB_CHANGE_GROUP_ENABLE,
  input  wire logic [7:0] PIN_CHANGE_MASK_B,
  input  wire logic       PORTC_CHANGE_GROUP_ENABLE,
  input  wire logic [6:5] PIN_CHANGE_MASK_C,
  input  wire logic       TWO_WIRE_ENABLE_BIT,
  input  wire logic       TWO_WIRE_SCL_PULL_LOW,
  input  wire logic [7:0] PAD_B_IN,
  input  wire logic [6:5] PAD_C_IN,
  output logic      [7:0] PAD_B_OUT,
  output logic      [7:0] PAD_B_OE_N,
  output logic      [7:0] PAD_B_PULLUP,
  output logic      [6:5] PAD_C_OUT,
  output logic      [6:5] PAD_C_OE_N,
  output logic      [6:5] PAD_C_PULLUP,
  output logic            SPI_SLAVE_SELECT_ACTIVE,
  output logic            SPI_SCK_IN,
  output logic            SPI_MASTER_IN,
  output logic            SPI_SLAVE_IN,
  output logic            TIMER16_CAPTURE_IN,
  output logic            TWO_WIRE_SCL_IN,
  output logic            EXT_RESET_REQ,
  output logic      [7:0] PIN_CHANGE_B,
  output logic      [6:5] PIN_CHANGE_C,
  output logic      [7:0] INPUT_ENABLE_B,
  output logic      [7:0] PINB_READ,
  output logic      [6:5] PINC_READ,
  output logic      [6:5] PORTC_DIR_READ,
  output logic      [6:5] PORTC_OUT_READ
);

  // ************************************************************
  // pad input synchronisers
  // ************************************************************
  logic [7:0]       b_meta_reg;
  logic [7:0]       b_sync_reg;
  logic [6:5]       c_meta_reg;
  logic [6:5]       c_sync_reg;

  // two flops per pad before any logic looks at it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      b_meta_reg <= '0;
      b_sync_reg <= '0;
      c_meta_reg <= '0;
      c_sync_reg <= '0;
    end else begin
      b_meta_reg <= PAD_B_IN;
      b_sync_reg <= b_meta_reg;
      c_meta_reg <= PAD_C_IN;
      c_sync_reg <= c_meta_reg;
    end
  end

  // ************************************************************
  // divided clock output
  // ************************************************************
  logic [CNT_W-1:0] divided_clock_out_cnt_reg;
  logic             divided_clock_out_reg;

  // free running, chip reset does not stop it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      divided_clock_out_cnt_reg <= '0;
      divided_clock_out_reg     <= '0;
    end else if (divided_clock_out_cnt_reg == CNT_W'(DIVIDED_CLOCK_OUT_HALF - 1)) begin
      divided_clock_out_cnt_reg <= '0;
      divided_clock_out_reg     <= ~divided_clock_out_reg;
    end else begin
      divided_clock_out_cnt_reg <= divided_clock_out_cnt_reg + CNT_W'(1);
    end
  end

  // ************************************************************
  // mode decode
  // ************************************************************
  logic spi_slave;
  logic spi_master;
  logic osc_b7;
  logic osc_b6;
  logic reset_mode;
  logic global_pullup_disable;

  assign spi_slave  = SPI_ENABLE_BIT & ~SPI_MASTER_SELECT;
  assign spi_master = SPI_ENABLE_BIT & SPI_MASTER_SELECT;
  assign osc_b7     = (INTERNAL_RC_SELECTED & EXTERNAL_CLOCK_SELECTED)
                    | ASYNC_TIMER_ENABLE;
  assign osc_b6     = INTERNAL_RC_SELECTED | ASYNC_TIMER_ENABLE;
  assign reset_mode = ~RESET_PIN_DISABLE_FUSE;
  assign global_pullup_disable        = GLOBAL_PULLUP_DISABLE;

  // ************************************************************
  // override sets per pin
  // ************************************************************
  paf_ovr_t ovr_b [8];
  paf_ovr_t ovr_c [7];

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ovr_b[i] = OVR_NONE;
      // change mask turns digital input on
      ovr_b[i].input_enable_override_enable =
        PIN_CHANGE_MASK_B[i] & PORTB_CHANGE_GROUP_ENABLE;
      ovr_b[i].input_enable_override_value  = 1'h1;
    end
    for (int i = 0; i < 7; i++) begin
      ovr_c[i] = OVR_NONE;
    end
    // b7/b6: oscillator pins, pull-up and driver off
    ovr_b[PB_OSC2].pullup_override_enable       = osc_b7;
    ovr_b[PB_OSC2].direction_override_enable    = osc_b7;
    ovr_b[PB_OSC2].input_enable_override_enable =
      osc_b7 | (PIN_CHANGE_MASK_B[PB_OSC2] & PORTB_CHANGE_GROUP_ENABLE);
    ovr_b[PB_OSC2].input_enable_override_value  = osc_b7 ?
      ((INTERNAL_RC_SELECTED | EXTERNAL_CLOCK_SELECTED) & ~ASYNC_TIMER_ENABLE)
      : 1'h1;
    ovr_b[PB_OSC1].pullup_override_enable       = osc_b6;
    ovr_b[PB_OSC1].direction_override_enable    = osc_b6;
    ovr_b[PB_OSC1].input_enable_override_enable =
      osc_b6 | (PIN_CHANGE_MASK_B[PB_OSC1] & PORTB_CHANGE_GROUP_ENABLE);
    ovr_b[PB_OSC1].input_enable_override_value  = osc_b6 ?
      (INTERNAL_RC_SELECTED & ASYNC_TIMER_ENABLE) : 1'h1;
    // b5: clock out as master, forced input as slave
    ovr_b[PB_SCK].pullup_override_enable    = spi_slave;
    ovr_b[PB_SCK].pullup_override_value     = PORTB_OUTPUT[PB_SCK] & ~global_pullup_disable;
    ovr_b[PB_SCK].direction_override_enable = spi_slave;
    ovr_b[PB_SCK].value_override_enable     = spi_master;
    ovr_b[PB_SCK].value_override_value      = SPI_SCK_OUT;
    // b4: master input forced, slave output data
    ovr_b[PB_MISO].pullup_override_enable    = spi_master;
    ovr_b[PB_MISO].pullup_override_value     = PORTB_OUTPUT[PB_MISO] & ~global_pullup_disable;
    ovr_b[PB_MISO].direction_override_enable = spi_master;
    ovr_b[PB_MISO].value_override_enable     = spi_slave;
    ovr_b[PB_MISO].value_override_value      = SPI_SLAVE_OUT;
    // b3: master out or 8-bit compare a, slave forced input
    ovr_b[PB_MOSI].pullup_override_enable    = spi_slave;
    ovr_b[PB_MOSI].pullup_override_value     = PORTB_OUTPUT[PB_MOSI] & ~global_pullup_disable;
    ovr_b[PB_MOSI].direction_override_enable = spi_slave;
    ovr_b[PB_MOSI].value_override_enable     = spi_master | TIMER8B_COMPARE_A_EN;
    ovr_b[PB_MOSI].value_override_value      = SPI_MASTER_OUT | TIMER8B_COMPARE_A_OUT;
    // b2: slave select forced input, compare b value
    ovr_b[PB_SS].pullup_override_enable    = spi_slave;
    ovr_b[PB_SS].pullup_override_value     = PORTB_OUTPUT[PB_SS] & ~global_pullup_disable;
    ovr_b[PB_SS].direction_override_enable = spi_slave;
    ovr_b[PB_SS].value_override_enable     = TIMER16_COMPARE_B_EN;
    ovr_b[PB_SS].value_override_value      = TIMER16_COMPARE_B_OUT;
    // b1: compare a value, direction left to register
    ovr_b[PB_TIMER16_COMPARE_A_OUT].value_override_enable   = TIMER16_COMPARE_A_EN;
    ovr_b[PB_TIMER16_COMPARE_A_OUT].value_override_value    = TIMER16_COMPARE_A_OUT;
    // b0: divided clock beats port and direction bits
    ovr_b[PB_DIVIDED_CLOCK_OUT].direction_override_enable = CLOCK_OUT_FUSE;
    ovr_b[PB_DIVIDED_CLOCK_OUT].direction_override_value  = 1'h1;
    ovr_b[PB_DIVIDED_CLOCK_OUT].value_override_enable     = CLOCK_OUT_FUSE;
    ovr_b[PB_DIVIDED_CLOCK_OUT].value_override_value      = divided_clock_out_reg;
    // c6: reset pin unless fuse programmed
    ovr_c[PC_RST].pullup_override_enable       = reset_mode;
    ovr_c[PC_RST].pullup_override_value        = 1'h1;
    ovr_c[PC_RST].direction_override_enable    = reset_mode;
    ovr_c[PC_RST].input_enable_override_enable =
      reset_mode | (PIN_CHANGE_MASK_C[PC_RST] & PORTC_CHANGE_GROUP_ENABLE);
    ovr_c[PC_RST].input_enable_override_value  = ~reset_mode;
    // c5: open-drain clock line, drive low only
    ovr_c[PC_SCL].pullup_override_enable       = TWO_WIRE_ENABLE_BIT;
    ovr_c[PC_SCL].pullup_override_value        = PORTC_OUTPUT[PC_SCL] & ~global_pullup_disable;
    ovr_c[PC_SCL].direction_override_enable    = TWO_WIRE_ENABLE_BIT;
    ovr_c[PC_SCL].direction_override_value     = TWO_WIRE_SCL_PULL_LOW;
    ovr_c[PC_SCL].value_override_enable        = TWO_WIRE_ENABLE_BIT;
    ovr_c[PC_SCL].input_enable_override_enable =
      PIN_CHANGE_MASK_C[PC_SCL] & PORTC_CHANGE_GROUP_ENABLE;
    ovr_c[PC_SCL].input_enable_override_value  = 1'h1;
  end

  // ************************************************************
  // pad resolution
  // ************************************************************
  paf_pad_t   pad_b [8];
  paf_pad_t   pad_c [7];
  logic [7:0] b_out_next;
  logic [7:0] b_oe_n_next;
  logic [7:0] b_pull_next;
  logic [6:5] c_out_next;
  logic [6:5] c_oe_n_next;
  logic [6:5] c_pull_next;
  logic [7:0] die_b;
  logic [6:5] die_c;

  // override first, register path second
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_b[i]       = paf_resolve(ovr_b[i], PORTB_OUTPUT[i], PORTB_DIRECTION[i],
                                   global_pullup_disable, ~SLEEP_INPUT_DISABLE);
      b_out_next[i]  = pad_b[i].out;
      b_oe_n_next[i] = ~pad_b[i].drive;
      b_pull_next[i] = pad_b[i].pull;
      die_b[i]       = pad_b[i].die;
    end
    for (int i = 0; i < 7; i++) begin
      pad_c[i] = OVR_NONE[3:0];
    end
    for (int i = PC_SCL; i <= PC_RST; i++) begin
      pad_c[i]       = paf_resolve(ovr_c[i], PORTC_OUTPUT[i], PORTC_DIRECTION[i],
                                   global_pullup_disable, ~SLEEP_INPUT_DISABLE);
      c_out_next[i]  = pad_c[i].out;
      c_oe_n_next[i] = ~pad_c[i].drive;
      c_pull_next[i] = pad_c[i].pull;
      die_c[i]       = pad_c[i].die;
    end
    // chip reset floats the pads, clock output and c6 pull-up excepted
    if (CHIP_RESET) begin
      b_oe_n_next = PB_OE_N_RST;
      b_pull_next = '0;
      c_oe_n_next = PC_OE_N_RST;
      c_pull_next[PC_SCL] = 1'h0;
      if (CLOCK_OUT_FUSE) begin
        b_oe_n_next[PB_DIVIDED_CLOCK_OUT] = 1'h0;
      end
    end
  end

  // ************************************************************
  // pad output registers
  // ************************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PAD_B_OUT    <= '0;
      PAD_B_OE_N   <= PB_OE_N_RST;
      PAD_B_PULLUP <= '0;
      PAD_C_OUT    <= '0;
      PAD_C_OE_N   <= PC_OE_N_RST;
      PAD_C_PULLUP <= '0;
    end else begin
      PAD_B_OUT    <= b_out_next;
      PAD_B_OE_N   <= b_oe_n_next;
      PAD_B_PULLUP <= b_pull_next;
      PAD_C_OUT    <= c_out_next;
      PAD_C_OE_N   <= c_oe_n_next;
      PAD_C_PULLUP <= c_pull_next;
    end
  end

  // ************************************************************
  // peripheral side inputs
  // ************************************************************
  logic scl_filt;

  paf_spike_filter #(
    .STABLE_CYCLES (SPIKE_FILTER_CYC)
  ) u_scl_filter (
    .clk_sys (CLK_SYS),
    .rst_n   (RST_N),
    .sample  (c_sync_reg[PC_SCL]),
    .level   (scl_filt)
  );

  // synchronised pad levels to the alternate functions
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SPI_SLAVE_SELECT_ACTIVE <= '0;
      SPI_SCK_IN              <= '0;
      SPI_MASTER_IN           <= '0;
      SPI_SLAVE_IN            <= '0;
      TIMER16_CAPTURE_IN      <= '0;
      TWO_WIRE_SCL_IN         <= SCL_IDLE;
      EXT_RESET_REQ           <= '0;
      PIN_CHANGE_B            <= '0;
      PIN_CHANGE_C            <= '0;
      INPUT_ENABLE_B          <= '0;
      PINB_READ               <= '0;
      PINC_READ               <= '0;
      PORTC_DIR_READ          <= '0;
      PORTC_OUT_READ          <= '0;
    end else begin
      SPI_SLAVE_SELECT_ACTIVE <= spi_slave & ~b_sync_reg[PB_SS];
      SPI_SCK_IN              <= b_sync_reg[PB_SCK];
      SPI_MASTER_IN           <= b_sync_reg[PB_MISO];
      SPI_SLAVE_IN            <= b_sync_reg[PB_MOSI];
      TIMER16_CAPTURE_IN      <= b_sync_reg[PB_DIVIDED_CLOCK_OUT];
      TWO_WIRE_SCL_IN         <= TWO_WIRE_ENABLE_BIT ? scl_filt : SCL_IDLE;
      EXT_RESET_REQ           <= reset_mode & ~c_sync_reg[PC_RST];
      PIN_CHANGE_B            <= b_sync_reg & die_b;
      PIN_CHANGE_C            <= c_sync_reg & die_c;
      INPUT_ENABLE_B          <= die_b;
      PINB_READ               <= b_sync_reg;
      // reset pin reads zero in all three bits
      PINC_READ               <= {c_sync_reg[PC_RST] & ~reset_mode,
                                  c_sync_reg[PC_SCL]};
      PORTC_DIR_READ          <= {PORTC_DIRECTION[PC_RST] & ~reset_mode,
                                  PORTC_DIRECTION[PC_SCL]};
      PORTC_OUT_READ          <= {PORTC_OUTPUT[PC_RST] & ~reset_mode,
                                  PORTC_OUTPUT[PC_SCL]};
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  sequence s_select_low;
    spi_slave && !b_sync_reg[PB_SS];
  endsequence

  property p_ss_input;
    spi_slave |=> PAD_B_OE_N[PB_SS];
  endproperty
  a_ss_input: assert property (p_ss_input)
    else $error("select pin not forced to input");

  property p_slave_active;
    s_select_low |=> SPI_SLAVE_SELECT_ACTIVE;
  endproperty
  a_slave_active: assert property (p_slave_active)
    else $error("slave not active with select low");

  property p_slave_idle;
    b_sync_reg[PB_SS] |=> !SPI_SLAVE_SELECT_ACTIVE;
  endproperty
  a_slave_idle: assert property (p_slave_idle)
    else $error("slave active with select high");

  property p_forced_pull;
    (spi_slave && !CHIP_RESET) |=>
      PAD_B_PULLUP[PB_SS] == ($past(PORTB_OUTPUT[PB_SS]) & ~$past(global_pullup_disable));
  endproperty
  a_forced_pull: assert property (p_forced_pull)
    else $error("forced input pull-up wrong");

  property p_cmp_b;
    (TIMER16_COMPARE_B_EN && PORTB_DIRECTION[PB_SS] && !spi_slave && !CHIP_RESET)
      |=> !PAD_B_OE_N[PB_SS] && PAD_B_OUT[PB_SS] == $past(TIMER16_COMPARE_B_OUT);
  endproperty
  a_cmp_b: assert property (p_cmp_b)
    else $error("compare b not on pad");

  property p_cmp_a;
    (TIMER16_COMPARE_A_EN && !CHIP_RESET)
      |=> PAD_B_OUT[PB_TIMER16_COMPARE_A_OUT] == $past(TIMER16_COMPARE_A_OUT)
       && PAD_B_OE_N[PB_TIMER16_COMPARE_A_OUT] == !$past(PORTB_DIRECTION[PB_TIMER16_COMPARE_A_OUT]);
  endproperty
  a_cmp_a: assert property (p_cmp_a)
    else $error("compare a not on pad");

  property p_divided_clock_out;
    CLOCK_OUT_FUSE |=> !PAD_B_OE_N[PB_DIVIDED_CLOCK_OUT] && PAD_B_OUT[PB_DIVIDED_CLOCK_OUT] == $past(divided_clock_out_reg);
  endproperty
  a_divided_clock_out: assert property (p_divided_clock_out)
    else $error("divided clock missing on pad");

  property p_change_die;
    (PIN_CHANGE_MASK_B[PB_TIMER16_COMPARE_A_OUT] && PORTB_CHANGE_GROUP_ENABLE)
      |=> INPUT_ENABLE_B[PB_TIMER16_COMPARE_A_OUT];
  endproperty
  a_change_die: assert property (p_change_die)
    else $error("change mask did not enable input");

  property p_osc_off;
    ASYNC_TIMER_ENABLE |=> PAD_B_OE_N[PB_OSC2] && PAD_B_OE_N[PB_OSC1]
                        && !PAD_B_PULLUP[PB_OSC2] && !PAD_B_PULLUP[PB_OSC1];
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator pin not released");

  property p_reset_reads;
    reset_mode |=> PINC_READ[PC_RST] == 1'h0 && PORTC_DIR_READ[PC_RST] == 1'h0
                && PORTC_OUT_READ[PC_RST] == 1'h0;
  endproperty
  a_reset_reads: assert property (p_reset_reads)
    else $error("reset pin bits not read as zero");

  property p_scl_open_drain;
    (TWO_WIRE_ENABLE_BIT && !CHIP_RESET)
      |=> PAD_C_OUT[PC_SCL] == 1'h0
       && PAD_C_OE_N[PC_SCL] == !$past(TWO_WIRE_SCL_PULL_LOW);
  endproperty
  a_scl_open_drain: assert property (p_scl_open_drain)
    else $error("clock line not open drain");

endmodule
`default_nettype wire

// >>> bench/paf_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// pad side: pins seen from the board
// ************************************************************
module paf_pad_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] o,
  input  wire logic [W-1:0] oe_n,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] ext,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin
);
  // own driver wins, then board driver, then pull-up, else inverse of own output bit
  assign pin = (~oe_n & o) | (oe_n & ext_en & ext) | (oe_n & ~ext_en & (pu | ~o));
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import paf_pkg::*;
;
  logic CLK_SYS = 1'h0, RST_N = 1'h0, CHIP_RESET = 1'h0, SLEEP_INPUT_DISABLE = 1'h0;
  logic GLOBAL_PULLUP_DISABLE = 1'h0, SPI_ENABLE_BIT = 1'h0, SPI_MASTER_SELECT = 1'h0;
  logic SPI_SCK_OUT = 1'h0, SPI_MASTER_OUT = 1'h0, SPI_SLAVE_OUT = 1'h0;
  logic TIMER16_COMPARE_A_EN = 1'h0, TIMER16_COMPARE_A_OUT = 1'h1, TIMER16_COMPARE_B_EN = 1'h0;
  logic TIMER16_COMPARE_B_OUT = 1'h1, TIMER8B_COMPARE_A_EN = 1'h0, TIMER8B_COMPARE_A_OUT = 1'h0;
  logic CLOCK_OUT_FUSE = 1'h0, RESET_PIN_DISABLE_FUSE = 1'h1, INTERNAL_RC_SELECTED = 1'h0;
  logic EXTERNAL_CLOCK_SELECTED = 1'h0, ASYNC_TIMER_ENABLE = 1'h0, TWO_WIRE_ENABLE_BIT = 1'h0;
  logic PORTB_CHANGE_GROUP_ENABLE = 1'h0, PORTC_CHANGE_GROUP_ENABLE = 1'h0;
  logic TWO_WIRE_SCL_PULL_LOW = 1'h0;
  logic [7:0] PORTB_OUTPUT = 8'hEF, PORTB_DIRECTION = 8'hFF, PIN_CHANGE_MASK_B = 8'h00;
  logic [6:5] PORTC_OUTPUT = 2'h0, PORTC_DIRECTION = 2'h0, PIN_CHANGE_MASK_C = 2'h0;
  logic [7:0] eb = 8'h00, ebe = 8'h00;
  logic [6:5] ec = 2'h0, ece = 2'h0;
  wire  [7:0] PAD_B_IN;
  wire  [6:5] PAD_C_IN;
  logic [7:0] PAD_B_OUT, PAD_B_OE_N, PAD_B_PULLUP, PIN_CHANGE_B, INPUT_ENABLE_B, PINB_READ;
  logic [6:5] PAD_C_OUT, PAD_C_OE_N, PAD_C_PULLUP, PIN_CHANGE_C, PINC_READ;
  logic [6:5] PORTC_DIR_READ, PORTC_OUT_READ;
  logic SPI_SLAVE_SELECT_ACTIVE, SPI_SCK_IN, SPI_MASTER_IN, SPI_SLAVE_IN;
  logic TIMER16_CAPTURE_IN, TWO_WIRE_SCL_IN, EXT_RESET_REQ, t;
  int err_total = 0, n_compared = 0, cyc = 0;

  paf_port_override i_dut (.*);
  paf_pad_model #(.W(8)) i_pad_b (.o(PAD_B_OUT), .oe_n(PAD_B_OE_N), .pu(PAD_B_PULLUP),
    .ext(eb), .ext_en(ebe), .pin(PAD_B_IN));
  paf_pad_model #(.W(2)) i_pad_c (.o(PAD_C_OUT), .oe_n(PAD_C_OE_N), .pu(PAD_C_PULLUP),
    .ext(ec), .ext_en(ece), .pin(PAD_C_IN));

  // ************************************************************
  // clock, timeout, helpers
  // ************************************************************
  initial begin
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (8) @(posedge CLK_SYS);
    RST_N <= 1'h1;
    SPI_ENABLE_BIT <= 1'h1;
    SPI_SLAVE_OUT <= 1'h1;
    w(3);
    chk("slave_oe_n", PAD_B_OE_N & 8'h2C, 8'h2C);
    chk("slave_pull", PAD_B_PULLUP & 8'h2C, 8'h2C);
    chk("miso_out", PAD_B_OUT[4], 8'h01);
    chk("ss_idle", SPI_SLAVE_SELECT_ACTIVE, 8'h00);
    @(posedge CLK_SYS);
    ebe <= 8'h04;
    GLOBAL_PULLUP_DISABLE <= 1'h1;
    w(4);
    chk("ss_low", SPI_SLAVE_SELECT_ACTIVE, 8'h01);
    chk("pud_pull", PAD_B_PULLUP[2], 8'h00);
    chk("pinb", PINB_READ, 8'hD3);
    chk("spi_in", {SPI_SCK_IN, SPI_MASTER_IN, SPI_SLAVE_IN}, 8'h02);
    ebe <= 8'h00;
    GLOBAL_PULLUP_DISABLE <= 1'h0;
    SPI_MASTER_SELECT <= 1'h1;
    SPI_SCK_OUT <= 1'h1;
    TIMER8B_COMPARE_A_EN <= 1'h1;
    TIMER8B_COMPARE_A_OUT <= 1'h1;
    w(2);
    chk("master", {PAD_B_OE_N[4], PAD_B_OUT[5], PAD_B_OUT[3]}, 8'h07);
    TIMER8B_COMPARE_A_OUT <= 1'h0;
    SPI_ENABLE_BIT <= 1'h0;
    TIMER16_COMPARE_A_EN <= 1'h1;
    TIMER16_COMPARE_B_EN <= 1'h1;
    TIMER16_COMPARE_A_OUT <= 1'h0;
    TIMER16_COMPARE_B_OUT <= 1'h0;
    w(2);
    chk("cmp_out", PAD_B_OUT & 8'h0E, 8'h00);
    PORTB_DIRECTION <= 8'h00;
    CLOCK_OUT_FUSE <= 1'h1;
    CHIP_RESET <= 1'h1;
    w(3);
    t = PAD_B_OUT[0];
    w(1);
    chk("divided_clock_out_tog", PAD_B_OUT[0], {7'h00, ~t});
    chk("divided_clock_out_oe", PAD_B_OE_N[0], 8'h00);
    CHIP_RESET <= 1'h0;
    CLOCK_OUT_FUSE <= 1'h0;
    ASYNC_TIMER_ENABLE <= 1'h1;
    INTERNAL_RC_SELECTED <= 1'h1;
    PORTB_CHANGE_GROUP_ENABLE <= 1'h1;
    PIN_CHANGE_MASK_B <= 8'hFF;
    SLEEP_INPUT_DISABLE <= 1'h1;
    w(2);
    chk("die", INPUT_ENABLE_B, 8'h7F);
    chk("osc", {PAD_B_PULLUP[7:6], PAD_B_OE_N[7:6]}, 8'h03);
    chk("cmp_dir", PAD_B_OE_N[2:1], 8'h03);
    ebe <= 8'h01;
    w(4);
    chk("capture", {TIMER16_CAPTURE_IN, PIN_CHANGE_B[0]}, 8'h00);
    RESET_PIN_DISABLE_FUSE <= 1'h0;
    ebe <= 8'h00;
    PORTC_OUTPUT <= 2'h3;
    PORTC_DIRECTION <= 2'h3;
    ece <= 2'h2;
    w(4);
    chk("rst_pin", {PORTC_DIR_READ[6], PORTC_OUT_READ[6], PINC_READ[6], EXT_RESET_REQ}, 8'h01);
    chk("capture_hi", {TIMER16_CAPTURE_IN, PIN_CHANGE_B[0]}, 8'h03);
    chk("c_pull", PAD_C_PULLUP, 8'h02);
    RESET_PIN_DISABLE_FUSE <= 1'h1;
    w(4);
    chk("gp_pin", {PORTC_DIR_READ[6], EXT_RESET_REQ}, 8'h02);
    TWO_WIRE_ENABLE_BIT <= 1'h1;
    TWO_WIRE_SCL_PULL_LOW <= 1'h1;
    w(2);
    chk("scl_low", {PAD_C_OE_N[5], PAD_C_OUT[5]}, 8'h00);
    TWO_WIRE_SCL_PULL_LOW <= 1'h0;
    ece <= 2'h1;
    w(3);
    ece <= 2'h0;
    w(12);
    chk("scl_spike", {PAD_C_OE_N[5], TWO_WIRE_SCL_IN}, 8'h03);
    ece <= 2'h1;
    w(12);
    chk("scl_in", TWO_WIRE_SCL_IN, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
